/* File: logic/pifc_debounce.sv */
// Purpose: Accepts a new level only after it has held for a number of debounce ticks.
// Assumes: level_i is already synchronous to clk_i; tick_i is a one-cycle strobe.
// Notes:   Any bounce restarts the stability count.
`default_nettype none
module pifc_debounce
  import pifc_pkg::*;
#(
  parameter int STABLE_TICKS = DB_STABLE_TICKS
)
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic ce_i,
  // Debounce timing
  input  wire logic tick_i,
  // Levels
  input  wire logic level_i,
  output logic      level_o
);

  logic       cand_reg;
  logic [3:0] cnt_reg;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cand_reg <= 1'b0;
      cnt_reg  <= 4'h0;
      level_o  <= 1'b0;
    end
    else if (ce_i)
    begin
      if (level_i != cand_reg)
      begin
        cand_reg <= level_i;
        cnt_reg  <= 4'h0;
      end
      else if (tick_i)
      begin
        if (cnt_reg == 4'(STABLE_TICKS - 1))
          level_o <= cand_reg;                              // see [RULE9]
        if (cnt_reg != 4'(STABLE_TICKS - 1))
          cnt_reg <= cnt_reg + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  chk_deb_on_tick: assert property (@(posedge clk_i) disable iff (!nrst_i) // see [RULE9]
    $changed(level_o) |-> $past(tick_i) && $past(level_i) == level_o)
    else $error("Debounced level changed without a tick.");

endmodule // pifc_debounce
`default_nettype wire

/* File: logic/pifc_pkg.sv */
// Purpose: Shared constants and types for the pin interrupt and fault control block.
// Assumes: 20 MHz system clock and 8-bit registers on a byte-wide register port.
// Notes:   Every offset, field position, reset value and timing count lives here.
`default_nettype none
package pifc_pkg;
  // Register offsets.
  localparam logic [7:0] OFS_FAULT_MASK  = 8'h2D;
  localparam logic [7:0] OFS_SHUTDOWN    = 8'h2E;
  localparam logic [7:0] OFS_HOLD        = 8'h2F;
  localparam logic [7:0] OFS_IRQ_CFG     = 8'h30;
  // Reset values.
  localparam logic [7:0] RST_FAULT_MASK  = 8'h01;
  localparam logic       RST_SD_RELEASE  = 1'b1;
  localparam logic       RST_HOLD_OFF    = 1'b0;
  localparam logic       RST_EDGE_MODE   = 1'b1;
  localparam logic       RST_POLARITY    = 1'b0;
  localparam logic [2:0] RST_SOURCE      = 3'h0;
  localparam logic [1:0] RST_DEBOUNCE_CLOCK_SELECT       = 2'h0;
  // Field positions.
  localparam int BIT_SD_RELEASE = 0;
  localparam int BIT_HOLD_OFF   = 5;
  localparam int BIT_EDGE_MODE  = 6;
  localparam int BIT_POLARITY   = 5;
  localparam int BIT_SRC_LO     = 2;
  localparam int BIT_DEBOUNCE_CLOCK_SELECT_LO   = 0;
  localparam int BIT_MASK_SHORT = 6;
  localparam int BIT_MASK_DSP   = 7;
  // Interrupt source codes.
  localparam logic [2:0] SRC_OFF  = 3'h0;
  localparam logic [2:0] SRC_PIN0 = 3'h4;
  localparam logic [2:0] SRC_PIN2 = 3'h6;
  // Timing.
  localparam int CLK_PERIOD_NS   = 50;
  localparam int DBC_BASE_NS     = 1000000;
  localparam int DBC_BASE_CYC    = DBC_BASE_NS / CLK_PERIOD_NS;
  localparam int DB_STABLE_TICKS = 4;
  localparam int TICK_W          = 24;

  typedef struct packed {
    logic       edge_mode;
    logic       polarity;
    logic [2:0] source;
    logic [1:0] debounce_clock_select;
  } pifc_irq_cfg_t;
endpackage : pifc_pkg
`default_nettype wire

/* File: logic/pifc_top.sv */
// Purpose: Fault interrupt masking, backend shutdown, sample hold and pin interrupt input.
// Assumes: Fault sources, processor interrupt and audio samples are on clk_i already.
// Notes:   Pin inputs are asynchronous and pass a three-stage synchroniser.
`default_nettype none
// What this block does
// [RULE1] Each of eight fault sources is gated by its own mask bit.
// [RULE2] Mask bit six gates the short-circuit flag.
// [RULE3] Mask bit seven gates the audio processor interrupt.
// [RULE4] Backend shutdown is active while the release bit is zero; it resets to one.
// [RULE5] On clock error the last good sample is held unless hold is disabled.
// [RULE6] Edge mode sends a rising-edge pulse; otherwise the level passes through.
// [RULE7] Polarity bit zero means active high, one means active low.
// [RULE8] Source field picks off, general pin zero or general pin two.
// [RULE9] A pin change is accepted after four stable debounce clock periods.
// [RULE10] Debounce clock select code zero gives about one millisecond.
// [RULE11] Outgoing interrupt is the OR of all masked fault sources.
// [RULE12] Polarity, then debounce, then optional edge detect, then processor port.
module pifc_top
  import pifc_pkg::*;
#(
  parameter int DBC_BASE_CYCLES = DBC_BASE_CYC,
  parameter int SAMPLE_W        = 24
)
(
  // Clock, reset and enable
  input  wire logic                clk_i,
  input  wire logic                nrst_i,
  input  wire logic                ce_i,
  // Register port
  input  wire logic [7:0]          reg_addr_i,
  input  wire logic [7:0]          reg_wdata_i,
  input  wire logic                reg_wr_i,
  output logic      [7:0]          reg_rdata_o,
  // Fault sources
  input  wire logic [5:0]          fault_src_i,
  input  wire logic                short_flag_i,
  input  wire logic                dsp_irq_i,
  output logic                     fault_irq_o,
  // Backend
  output logic                     backend_shutdown_o,
  // Audio samples
  input  wire logic                clk_err_i,
  input  wire logic                sample_valid_i,
  input  wire logic [SAMPLE_W-1:0] sample_i,
  output logic      [SAMPLE_W-1:0] dac_sample_o,
  // Interrupt pins and processor port
  input  wire logic                general_pin_zero_i,
  input  wire logic                general_pin_two_i,
  output logic                     proc_irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers.
  logic [7:0]    fault_irq_mask_reg;
  logic          backend_shutdown_release_reg;
  logic          hold_last_sample_off_reg;
  pifc_irq_cfg_t cfg_reg;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      fault_irq_mask_reg           <= RST_FAULT_MASK;
      backend_shutdown_release_reg <= RST_SD_RELEASE;                // see [RULE4]
      hold_last_sample_off_reg     <= RST_HOLD_OFF;
      cfg_reg                      <= '{RST_EDGE_MODE, RST_POLARITY, RST_SOURCE, RST_DEBOUNCE_CLOCK_SELECT};
    end
    else if (ce_i && reg_wr_i)
    begin
      case (reg_addr_i)
        OFS_FAULT_MASK: fault_irq_mask_reg           <= reg_wdata_i;
        OFS_SHUTDOWN:   backend_shutdown_release_reg <= reg_wdata_i[BIT_SD_RELEASE];
        OFS_HOLD:       hold_last_sample_off_reg     <= reg_wdata_i[BIT_HOLD_OFF];
        OFS_IRQ_CFG:
        begin
          cfg_reg.edge_mode <= reg_wdata_i[BIT_EDGE_MODE];
          cfg_reg.polarity  <= reg_wdata_i[BIT_POLARITY];
          cfg_reg.source    <= reg_wdata_i[BIT_SRC_LO +: 3];
          cfg_reg.debounce_clock_select     <= reg_wdata_i[BIT_DEBOUNCE_CLOCK_SELECT_LO +: 2];
        end
        default: ;
      endcase
    end
  end

  // Reserved bits read as zero; unmapped offsets read as zero.
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      reg_rdata_o <= 8'h00;
    else if (ce_i)
    begin
      case (reg_addr_i)
        OFS_FAULT_MASK: reg_rdata_o <= fault_irq_mask_reg;
        OFS_SHUTDOWN:   reg_rdata_o <= {7'h00, backend_shutdown_release_reg};
        OFS_HOLD:       reg_rdata_o <= {2'h0, hold_last_sample_off_reg, 5'h00};
        OFS_IRQ_CFG:    reg_rdata_o <= {1'b0, cfg_reg};
        default:        reg_rdata_o <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outgoing fault interrupt.
  logic [7:0] fault_vec;

  assign fault_vec = {dsp_irq_i, short_flag_i, fault_src_i};  // see [RULE2] see [RULE3]

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      fault_irq_o <= 1'b0;
    else if (ce_i)
      fault_irq_o <= |(fault_vec & fault_irq_mask_reg);      // see [RULE1] see [RULE11]
  end

  // Shutdown is the inverse of the release flop, with no register between.
  assign backend_shutdown_o = ~backend_shutdown_release_reg;  // see [RULE4]

  ////////////////////////////////////////////////////////////////////////////
  // Last sample hold.
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      dac_sample_o <= '0;
    else if (ce_i && sample_valid_i && !(clk_err_i && !hold_last_sample_off_reg))
      dac_sample_o <= sample_i;                               // see [RULE5]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; a level is only taken once stages two and three agree.
  logic [1:0] pin_raw;
  logic [1:0] pin_level_reg;

  assign pin_raw = {general_pin_two_i, general_pin_zero_i};

  for (genvar g = 0; g < 2; g++)
  begin : g_sync
    logic [2:0] sync_reg;
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
      if (!nrst_i)
      begin
        sync_reg         <= 3'h0;
        pin_level_reg[g] <= 1'b0;
      end
      else if (ce_i)
      begin
        sync_reg <= {sync_reg[1:0], pin_raw[g]};
        if (sync_reg[1] == sync_reg[2])
          pin_level_reg[g] <= sync_reg[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source select and polarity ahead of the debouncer.
  logic src_on;
  logic sel_level;
  logic pol_level;

  always_comb
  begin
    src_on    = 1'b1;
    sel_level = 1'b0;
    case (cfg_reg.source)                                     // see [RULE8]
      SRC_PIN0: sel_level = pin_level_reg[0];
      SRC_PIN2: sel_level = pin_level_reg[1];
      default:  src_on    = 1'b0;
    endcase
  end

  // Polarity is fixed first so the debouncer always sees an active-high level.
  assign pol_level = src_on & (sel_level ^ cfg_reg.polarity); // see [RULE7] see [RULE12]

  ////////////////////////////////////////////////////////////////////////////
  // Debounce tick; codes above zero double the period per step.
  logic [TICK_W-1:0] tick_cnt_reg;
  logic [TICK_W-1:0] tick_period;
  logic              tick;

  assign tick_period = TICK_W'(DBC_BASE_CYCLES) << cfg_reg.debounce_clock_select; // see [RULE10]
  assign tick        = (tick_cnt_reg >= tick_period - TICK_W'(1));

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      tick_cnt_reg <= '0;
    else if (ce_i)
      tick_cnt_reg <= tick ? '0 : tick_cnt_reg + TICK_W'(1);
  end

  logic deb_level;

  pifc_debounce #(
    .STABLE_TICKS (DB_STABLE_TICKS)
  ) u_debounce (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .ce_i    (ce_i),
    .tick_i  (tick),
    .level_i (pol_level),
    .level_o (deb_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Edge or level toward the processor.
  logic deb_prev_reg;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      deb_prev_reg <= 1'b0;
      proc_irq_o   <= 1'b0;
    end
    else if (ce_i)
    begin
      deb_prev_reg <= deb_level;
      if (!src_on)
        proc_irq_o <= 1'b0;                                   // see [RULE8]
      else if (cfg_reg.edge_mode)
        proc_irq_o <= deb_level & ~deb_prev_reg;              // see [RULE6] see [RULE12]
      else
        proc_irq_o <= deb_level;                              // see [RULE6]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  // A period change mid-count is exempt from the tick check until the next tick restarts it.
  logic [TICK_W-1:0] since_tick_reg;
  logic              period_steady_reg;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      since_tick_reg    <= '0;
      period_steady_reg <= 1'b1;
    end
    else if (ce_i)
    begin
      since_tick_reg <= tick ? '0 : since_tick_reg + TICK_W'(1);
      if (tick)
        period_steady_reg <= 1'b1;
      else if (reg_wr_i && reg_addr_i == OFS_IRQ_CFG)
        period_steady_reg <= 1'b0;
    end
  end

  sequence s_wr_mask(logic [7:0] m);
    ce_i && reg_wr_i && reg_addr_i == OFS_FAULT_MASK && reg_wdata_i == m;
  endsequence

  chk_mask_gate_out: assert property (@(posedge clk_i) disable iff (!nrst_i) // see [RULE1]
    ce_i |=> fault_irq_o == |($past(fault_vec) & $past(fault_irq_mask_reg)))
    else $error("Fault interrupt does not match masked sources.");

  chk_short_mask_on: assert property (@(posedge clk_i) disable iff (!nrst_i) // see [RULE2]
    s_wr_mask(8'h40) ##1 (ce_i && short_flag_i) |=> fault_irq_o)
    else $error("Unmasked short flag did not raise the interrupt.");

  chk_dsp_mask_off: assert property (@(posedge clk_i) disable iff (!nrst_i) // see [RULE3]
    s_wr_mask(8'h00) ##1 (ce_i && dsp_irq_i) |=> !fault_irq_o)
    else $error("Masked processor interrupt raised the interrupt.");

  chk_shutdown_write: assert property (@(posedge clk_i) disable iff (!nrst_i) // see [RULE4]
    ce_i && reg_wr_i && reg_addr_i == OFS_SHUTDOWN
    |=> backend_shutdown_o == !$past(reg_wdata_i[0]))
    else $error("Backend shutdown does not follow the release bit.");

  chk_sample_hold: assert property (@(posedge clk_i) disable iff (!nrst_i) // see [RULE5]
    clk_err_i && !hold_last_sample_off_reg |=> $stable(dac_sample_o))
    else $error("Sample changed during a clock error with hold on.");

  chk_edge_single: assert property (@(posedge clk_i) disable iff (!nrst_i) // see [RULE6]
    ce_i && cfg_reg.edge_mode && proc_irq_o ##1 ce_i && cfg_reg.edge_mode |-> !proc_irq_o)
    else $error("Edge-mode interrupt lasted more than one cycle.");

  chk_pol_apply: assert property (@(posedge clk_i) disable iff (!nrst_i) // see [RULE7]
    cfg_reg.source == SRC_PIN2 |-> pol_level == (pin_level_reg[1] ^ cfg_reg.polarity))
    else $error("Polarity not applied to the selected pin.");

  chk_src_off: assert property (@(posedge clk_i) disable iff (!nrst_i) // see [RULE8]
    ce_i && cfg_reg.source == SRC_OFF |=> !proc_irq_o)
    else $error("Processor interrupt raised while source disabled.");

  chk_tick_period: assert property (@(posedge clk_i) disable iff (!nrst_i) // see [RULE10]
    ce_i && period_steady_reg
    |-> since_tick_reg == tick_cnt_reg && tick == (since_tick_reg == tick_period - TICK_W'(1)))
    else $error("Debounce tick period wrong.");

endmodule // pifc_top
`default_nettype wire

/* File: verif/pifc_host_model.sv */
// Purpose: Host side of the register port, issuing byte writes and reads.
// Assumes: The device takes requests on the rising edge of clk_i.
// Notes:   Requests change on the falling edge so they are settled at the sampling edge.
`default_nettype none
module pifc_host_model
  import pifc_pkg::*;
(
  // Clock
  input  wire logic       clk_i,
  // Register port
  output logic      [7:0] reg_addr_o,
  output logic      [7:0] reg_wdata_o,
  output logic            reg_wr_o,
  input  wire logic [7:0] reg_rdata_i
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o    = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_addr_o  = a;
    reg_wdata_o = d;
    reg_wr_o    = 1'b1;
    @(negedge clk_i);
    reg_wr_o    = 1'b0;
    // Idle data is inverted so a stale byte can never pass for a fresh one.
    reg_wdata_o = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    reg_addr_o = a;
    @(negedge clk_i);
    d = reg_rdata_i;
  endtask
endmodule // pifc_host_model
`default_nettype wire

/* File: verif/testbench.sv */
// Purpose: Self-checking bench for the pin interrupt and fault control block.
// Assumes: Debounce base period shortened to 4 cycles.
// Notes:   Expected values come from a small integer model kept in the bench.
`default_nettype none
module testbench
  import pifc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SW = 24;
  logic          clk_i, nrst_i, ce_i, dsp, shrt, err, vld, pin0, pin2;
  logic          firq, sd, pirq;
  logic [5:0]    fsrc;
  logic [SW-1:0] smp, dac, held;
  logic [7:0]    addr, wdata, rdata, d;
  logic          wr;
  logic [31:0]   v;
  logic [2:0]    src;
  int            n_mismatch, samples_checked, ones, first;
  integer        seed = 7168;
  logic [7:0]    rofs [5] = '{8'h2D, 8'h2E, 8'h2F, 8'h30, 8'h31};
  logic [7:0]    rval [5] = '{8'h01, 8'h01, 8'h00, 8'h40, 8'h00};
  logic          herr [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
  logic [7:0]    pcfg [8] = '{8'h10, 8'h10, 8'h18, 8'h38, 8'h38, 8'h00, 8'h0C, 8'h11};
  logic [1:0]    ppin [8] = '{2'h1, 2'h2, 2'h2, 2'h2, 2'h0, 2'h3, 2'h3, 2'h1};
  ////////////////////////////////////////////////////////////////////////////////
  pifc_host_model u_host (.clk_i(clk_i), .reg_addr_o(addr), .reg_wdata_o(wdata),
                          .reg_wr_o(wr), .reg_rdata_i(rdata));
  pifc_top #(.DBC_BASE_CYCLES(4), .SAMPLE_W(SW)) u_dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rdata_o(rdata), .fault_src_i(fsrc), .short_flag_i(shrt),
    .dsp_irq_i(dsp), .fault_irq_o(firq), .backend_shutdown_o(sd), .clk_err_i(err),
    .sample_valid_i(vld), .sample_i(smp), .dac_sample_o(dac),
    .general_pin_zero_i(pin0), .general_pin_two_i(pin2), .proc_irq_o(pirq));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // The whole sequence needs about 1400 cycles; the limit leaves ample margin.
  initial
  begin
    repeat (6000) @(posedge clk_i);
    n_mismatch++;
    summarize();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    nrst_i = 1'b0;
    ce_i   = 1'b1;
    fsrc   = 6'h00;
    shrt   = 1'b0;
    dsp    = 1'b0;
    err    = 1'b0;
    vld    = 1'b0;
    smp    = '0;
    pin0   = 1'b0;
    pin2   = 1'b0;
    repeat (20) @(negedge clk_i);
    nrst_i = 1'b1;
    chk(sd, 1'b0);
    foreach (rofs[i])
    begin
      u_host.rd(rofs[i], d);
      chk(d, rval[i]);
    end
    u_host.wr(OFS_SHUTDOWN, 8'hFE);
    chk(sd, 1'b1);
    u_host.rd(OFS_SHUTDOWN, d);
    chk(d, 8'h00);
    u_host.wr(OFS_SHUTDOWN, 8'hFF);
    chk(sd, 1'b0);
    // A write while the clock enable is low must not land.
    ce_i = 1'b0;
    u_host.wr(OFS_SHUTDOWN, 8'hFE);
    chk(sd, 1'b0);
    ce_i = 1'b1;
    u_host.rd(OFS_SHUTDOWN, d);
    chk(d, 8'h01);
    // Random masks against random fault vectors; the last two aim at bits six and seven.
    for (int k = 0; k < 26; k++)
    begin
      v = $random(seed);
      if (k == 24)
        v[15:0] = 16'h4040;
      if (k == 25)
        v[15:0] = 16'h8000;
      u_host.wr(OFS_FAULT_MASK, v[7:0]);
      {dsp, shrt, fsrc} = v[15:8];
      @(negedge clk_i);
      chk(firq, |(v[7:0] & v[15:8]));
    end
    {dsp, shrt, fsrc} = 8'h00;
    u_host.wr(OFS_HOLD, 8'h00);
    foreach (herr[i])
    begin
      if (i == 3)
        u_host.wr(OFS_HOLD, 8'hFF);
      v = $random(seed);
      err = herr[i];
      vld = 1'b1;
      smp = v[SW-1:0];
      if (!(herr[i] && i < 3))
        held = v[SW-1:0];
      @(negedge clk_i);
      vld = 1'b0;
      chk(dac, held);
    end
    err = 1'b0;
    u_host.rd(OFS_HOLD, d);
    chk(d, 8'h20);
    foreach (pcfg[i])
    begin
      u_host.wr(OFS_IRQ_CFG, pcfg[i]);
      {pin2, pin0} = ppin[i];
      repeat (100) @(negedge clk_i);
      src = pcfg[i][4:2];
      v[0] = (src == SRC_PIN0) ? pin0 ^ pcfg[i][5] : (src == SRC_PIN2) ? pin2 ^ pcfg[i][5] : 1'b0;
      chk(pirq, v[0]);
    end
    // A pulse of six cycles spans under two debounce ticks and must be dropped.
    u_host.wr(OFS_IRQ_CFG, 8'h10);
    {pin2, pin0} = 2'h0;
    repeat (100) @(negedge clk_i);
    pin0 = 1'b1;
    repeat (6) @(negedge clk_i);
    pin0 = 1'b0;
    ones = 0;
    repeat (100)
    begin
      @(negedge clk_i);
      ones += (pirq !== 1'b0);
    end
    chk(ones, 0);
    u_host.wr(OFS_IRQ_CFG, 8'h50);
    repeat (100) @(negedge clk_i);
    pin0 = 1'b1;
    ones = 0;
    first = 0;
    for (int k = 0; k < 120; k++)
    begin
      @(negedge clk_i);
      if (pirq === 1'b1 && ones == 0)
        first = k;
      ones += (pirq !== 1'b0);
    end
    chk(ones, 1);
    chk(first >= 12, 1'b1);
    summarize();
  end
endmodule // testbench
`default_nettype wire
